// ---- hw/tmr8_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_n_in,
  input  wire tmr8_pkg::tmr8_cfg_t cfg_in,
  input  wire tmr8_pkg::tmr8_cpu_t cpu_in,
  input  wire logic                crystal_pin_in,
  output logic                     crystal_pin_out,
  output logic [7:0]               counter_value_out,
  output logic [7:0]               compare_value_out,
  output logic                     compare_flag_out,
  output logic                     overflow_flag_out,
  output logic                     compare_irq_out,
  output logic                     overflow_irq_out,
  output logic                     compare_output_out,
  output logic                     bottom_out,
  output logic                     max_out
);
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] cmp_active;
    logic [7:0] cmp_buffer;
    logic       down;
    logic       block;
    logic       cmp_flag;
    logic       ovf_flag;
    logic       cmp_irq;
    logic       ovf_irq;
    logic       oc;
    logic       xtal_out;
    logic       bottom;
    logic       max;
  } tmr8_st_t;

  tmr8_st_t             st_q;
  tmr8_st_t             st_d;
  logic                 tick;
  logic                 pwm;
  logic                 match;
  logic                 at_top;
  logic                 set_cmp;
  logic                 set_ovf;
  logic                 oc_apply;
  logic                 oc_val;
  logic [7:0]           top_val;
  tmr8_pkg::tmr8_mode_t mode;

  tmr8_tick_gen u_tick (
    .sys_clk_in            (sys_clk_in),
    .rst_n_in              (rst_n_in),
    .clock_select_field_in (cfg_in.clock_select_field),
    .async_clock_select_in (cfg_in.async_clock_select),
    .crystal_pin_in        (crystal_pin_in),
    .timer_tick_out        (tick)
  );

  always_comb begin
    st_d     = st_q;
    mode     = cfg_in.waveform_mode_field;
    pwm      = (mode == tmr8_pkg::TMR8_PHASE) || (mode == tmr8_pkg::TMR8_FAST);
    match    = st_q.count == st_q.cmp_active;
    top_val  = (mode == tmr8_pkg::TMR8_CTC) ? st_q.cmp_active : tmr8_pkg::TMR8_MAX;
    at_top   = st_q.count == top_val;
    set_cmp  = 1'b0;
    set_ovf  = 1'b0;
    oc_apply = 1'b0;
    oc_val   = st_q.oc;
    st_d.xtal_out = ~crystal_pin_in;
    if (tick) begin
      // blocked match cleared after a tick
      st_d.block = 1'b0;
      // match sets flag on following tick
      set_cmp  = match & ~st_q.block;
      oc_apply = set_cmp;
      unique case (mode)
        tmr8_pkg::TMR8_NORMAL: begin
          st_d.count = st_q.count + 8'h01;
          set_ovf = st_q.count == tmr8_pkg::TMR8_MAX;
        end
        tmr8_pkg::TMR8_CTC: begin
          st_d.count = at_top ? tmr8_pkg::TMR8_BOTTOM : st_q.count + 8'h01;
          set_ovf = st_q.count == tmr8_pkg::TMR8_MAX;
        end
        tmr8_pkg::TMR8_FAST: begin
          st_d.count = st_q.count + 8'h01;
          set_ovf = at_top;
        end
        tmr8_pkg::TMR8_PHASE: begin
          if (st_q.count == tmr8_pkg::TMR8_MAX) begin
            st_d.down = 1'b1;
          end else if (st_q.count == tmr8_pkg::TMR8_BOTTOM) begin
            st_d.down = 1'b0;
          end
          st_d.count = st_d.down ? st_q.count - 8'h01 : st_q.count + 8'h01;
          set_ovf = st_q.count == tmr8_pkg::TMR8_BOTTOM;
        end
      endcase
      // buffered update at top, in both fast and phase modes
      if (mode == tmr8_pkg::TMR8_FAST && at_top) begin
        st_d.cmp_active = st_q.cmp_buffer;
      end
      if (mode == tmr8_pkg::TMR8_PHASE && st_q.count == tmr8_pkg::TMR8_MAX) begin
        st_d.cmp_active = st_q.cmp_buffer;
      end
    end
    // forced match, no flag or clear
    if (cpu_in.force_compare_strobe && !pwm) begin
      oc_apply = 1'b1;
    end
    unique case (cfg_in.compare_output_action)
      2'h0: oc_val = st_q.oc;
      2'h1: oc_val = pwm ? st_q.oc : ~st_q.oc;
      2'h2: oc_val = (mode == tmr8_pkg::TMR8_PHASE) ? st_d.down : 1'b0;
      2'h3: oc_val = (mode == tmr8_pkg::TMR8_PHASE) ? ~st_d.down : 1'b1;
    endcase
    if (oc_apply) begin
      st_d.oc = oc_val;
    end
    if (tick && mode == tmr8_pkg::TMR8_FAST && at_top) begin
      if (cfg_in.compare_output_action == 2'h2) begin
        st_d.oc = 1'b1;
      end else if (cfg_in.compare_output_action == 2'h3) begin
        st_d.oc = 1'b0;
      end
    end
    if (cpu_in.counter_wr) begin
      st_d.count = cpu_in.counter_wdata;
      st_d.block = 1'b1;
    end
    if (cpu_in.compare_wr) begin
      st_d.cmp_buffer = cpu_in.compare_wdata;
      if (!pwm) begin
        st_d.cmp_active = cpu_in.compare_wdata;
      end
    end
    if (cpu_in.compare_flag_clr || cpu_in.compare_irq_ack) begin
      st_d.cmp_flag = 1'b0;
    end
    if (set_cmp) begin
      st_d.cmp_flag = 1'b1;
    end
    if (cpu_in.overflow_flag_clr || cpu_in.overflow_irq_ack) begin
      st_d.ovf_flag = 1'b0;
    end
    if (set_ovf) begin
      st_d.ovf_flag = 1'b1;
    end
    st_d.cmp_irq = st_d.cmp_flag & cfg_in.compare_irq_enable;
    st_d.ovf_irq = st_d.ovf_flag & cfg_in.overflow_irq_enable;
    st_d.bottom = st_d.count == tmr8_pkg::TMR8_BOTTOM;
    st_d.max    = st_d.count == tmr8_pkg::TMR8_MAX;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{count: tmr8_pkg::TMR8_RST8, cmp_active: tmr8_pkg::TMR8_RST8,
                cmp_buffer: tmr8_pkg::TMR8_RST8, bottom: 1'b1, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign counter_value_out  = st_q.count;
  assign compare_value_out  = st_q.cmp_buffer;
  assign compare_flag_out   = st_q.cmp_flag;
  assign overflow_flag_out  = st_q.ovf_flag;
  assign compare_irq_out    = st_q.cmp_irq;
  assign overflow_irq_out   = st_q.ovf_irq;
  assign compare_output_out = st_q.oc;
  assign crystal_pin_out    = st_q.xtal_out;
  assign bottom_out         = st_q.bottom;
  assign max_out            = st_q.max;
endmodule
`default_nettype wire

// ---- hw/tmr8_pkg.sv ----
// Operation
// - 8-bit counter and compare, compared continuously
// - tick from io clock or crystal
// - clock select zero stops the counter
// - counter readable and writable at any time
// - cpu counter write beats count operations
// - tick clears, increments or decrements counter
// - bottom at 0x00, maximum at 0xFF
// - top is 0xFF or compare value
// - match sets compare flag next tick
// - enabled flag raises irq, service clears
// - writing one clears compare flag
// - flags visible, each individually masked
// - compare double buffered in pwm modes
// - cpu reaches buffer or active compare
// - force strobe acts without flag or clear, in non-pwm modes only
// - counter write blocks next tick match
// - output action bits take effect at the next compare match, non-pwm force strobe or fast pwm top
// - output state kept across mode changes
// - overflow flag set per mode, irq capable
// - mode zero normal, wraps, overflow at zero
// - mode two clears on compare match
// - mode three fast pwm bottom to max
// - action zero leaves output unchanged
package tmr8_pkg;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX    = 8'hFF;
  localparam logic [7:0] TMR8_RST8   = 8'h00;
  localparam logic [9:0] TMR8_PRE_RST = 10'h000;

  typedef enum logic [1:0] {
    TMR8_NORMAL = 2'h0,
    TMR8_PHASE  = 2'h1,
    TMR8_CTC    = 2'h2,
    TMR8_FAST   = 2'h3
  } tmr8_mode_t;

  typedef struct packed {
    logic [2:0] clock_select_field;
    tmr8_mode_t waveform_mode_field;
    logic [1:0] compare_output_action;
    logic       async_clock_select;
    logic       compare_irq_enable;
    logic       overflow_irq_enable;
  } tmr8_cfg_t;

  typedef struct packed {
    logic       counter_wr;
    logic [7:0] counter_wdata;
    logic       compare_wr;
    logic [7:0] compare_wdata;
    logic       force_compare_strobe;
    logic       compare_flag_clr;
    logic       overflow_flag_clr;
    logic       compare_irq_ack;
    logic       overflow_irq_ack;
  } tmr8_cpu_t;
endpackage

// ---- hw/tmr8_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr8_tick_gen (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] clock_select_field_in,
  input  wire logic       async_clock_select_in,
  input  wire logic       crystal_pin_in,
  output logic            timer_tick_out
);
  typedef struct packed {
    logic [9:0] pre;
    logic [2:0] xtal_sync;
    logic       tick;
  } tmr8_tick_st_t;

  tmr8_tick_st_t st_q;
  tmr8_tick_st_t st_d;
  logic          src_tick;
  logic          sel_tick;

  always_comb begin
    st_d = st_q;
    st_d.pre = st_q.pre + 10'h001;
    st_d.xtal_sync = {st_q.xtal_sync[1:0], crystal_pin_in};
    // crystal rising edge or io clock
    src_tick = async_clock_select_in ? (st_q.xtal_sync[1] & ~st_q.xtal_sync[2]) : 1'b1;
    unique case (clock_select_field_in)
      3'h0: sel_tick = 1'b0;
      3'h1: sel_tick = 1'b1;
      3'h2: sel_tick = st_q.pre[2:0] == 3'h7;
      3'h3: sel_tick = st_q.pre[4:0] == 5'h1F;
      3'h4: sel_tick = st_q.pre[5:0] == 6'h3F;
      3'h5: sel_tick = st_q.pre[6:0] == 7'h7F;
      3'h6: sel_tick = st_q.pre[7:0] == 8'hFF;
      3'h7: sel_tick = st_q.pre == 10'h3FF;
    endcase
    if (async_clock_select_in) begin
      if (!src_tick) begin
        st_d.pre = st_q.pre;
      end
    end
    st_d.tick = src_tick & sel_tick;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '{pre: tmr8_pkg::TMR8_PRE_RST, xtal_sync: 3'h0, tick: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign timer_tick_out = st_q.tick;
endmodule
`default_nettype wire

// ---- dv/tmr8_timer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_chk (
  input wire logic                sys_clk_in,
  input wire logic                rst_n_in,
  input wire tmr8_pkg::tmr8_cfg_t cfg_in,
  input wire tmr8_pkg::tmr8_cpu_t cpu_in,
  input wire logic [7:0]          counter_value_out,
  input wire logic                compare_flag_out,
  input wire logic                overflow_flag_out,
  input wire logic                compare_irq_out,
  input wire logic                compare_output_out,
  input wire logic                bottom_out,
  input wire logic                max_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_stop;
    (cfg_in.clock_select_field == 3'h0 && !cpu_in.counter_wr) [*2];
  endsequence
  sequence s_wrap;
    counter_value_out == 8'hFF && !cpu_in.counter_wr ##1 counter_value_out == 8'h00;
  endsequence
  cnt_write_a: assert property (
    cpu_in.counter_wr |=> counter_value_out == $past(cpu_in.counter_wdata)) else $error("write lost");
  stop_hold_a: assert property (
    s_stop |=> $stable(counter_value_out)) else $error("count while stopped");
  ends_flag_a: assert property (
    bottom_out == (counter_value_out == 8'h00) && max_out == (counter_value_out == 8'hFF))
    else $error("bottom or max wrong");
  irq_mask_a: assert property (
    (!cfg_in.compare_irq_enable) [*2] |-> !compare_irq_out) else $error("masked irq seen");
  irq_raise_a: assert property (
    (compare_flag_out && cfg_in.compare_irq_enable) [*2] |-> compare_irq_out) else $error("irq lost");
  force_act_a: assert property (
    s_stop ##0 cpu_in.force_compare_strobe && !compare_flag_out && cfg_in.compare_output_action == 2'h1
    && cfg_in.waveform_mode_field == tmr8_pkg::TMR8_NORMAL |=> compare_output_out !=
    $past(compare_output_out) && !compare_flag_out) else $error("force wrong");
  oc_hold_a: assert property (
    (cfg_in.compare_output_action == 2'h0) [*2] |=> $stable(compare_output_out)) else $error("oc moved");
  match_block_a: assert property (
    cpu_in.counter_wr && cpu_in.compare_wr && cpu_in.compare_wdata == cpu_in.counter_wdata &&
    cfg_in.clock_select_field == 3'h0 && !compare_flag_out |=> !compare_flag_out [*3])
    else $error("match not blocked");
  ovf_set_a: assert property (
    s_wrap |-> ##[0:1] overflow_flag_out) else $error("no overflow");
endmodule
bind tmr8_timer tmr8_timer_chk u_chk (.sys_clk_in, .rst_n_in, .cfg_in, .cpu_in, .counter_value_out,
  .compare_flag_out, .overflow_flag_out, .compare_irq_out, .compare_output_out, .bottom_out, .max_out);
`default_nettype wire

// ---- dv/tmr8_timer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_bench;
  logic                sys_clk_in  = 1'b0;
  logic                rst_n_in    = 1'b0;
  logic                xtal        = 1'b0;
  tmr8_pkg::tmr8_cfg_t cfg         = '0;
  tmr8_pkg::tmr8_cpu_t cpu         = '0;
  logic [7:0]          cnt;
  logic [7:0]          cmpv;
  logic                cflag;
  logic                oflag;
  logic                cirq;
  logic                oirq;
  logic                oc;
  logic                xpo;
  logic                up          = 1'b1;
  int                  error_cnt   = 0;
  int                  comparisons = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  always #16 xtal = ~xtal;
  tmr8_timer dut (.sys_clk_in, .rst_n_in, .cfg_in(cfg), .cpu_in(cpu), .crystal_pin_in(xtal),
    .crystal_pin_out(xpo), .counter_value_out(cnt), .compare_value_out(cmpv),
    .compare_flag_out(cflag), .overflow_flag_out(oflag), .compare_irq_out(cirq),
    .overflow_irq_out(oirq),
    .compare_output_out(oc), .bottom_out(), .max_out());
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic pulse(input tmr8_pkg::tmr8_cpu_t p);
    cpu = p;
    cyc(1);
    cpu = '0;
    cyc(1);
  endtask
  // reference count step per mode
  function logic [7:0] nxt(input int m, input logic [7:0] c, input logic [7:0] k);
    if (m == 2 && c == k) return 8'h00;
    if (m != 1) return c + 8'h01;
    if (c == 8'hFF) up = 1'b0;
    if (c == 8'h00) up = 1'b1;
    return up ? c + 8'h01 : c - 8'h01;
  endfunction
  task automatic run(input int m, input logic [7:0] s, input logic [7:0] k, input int n,
                     input logic as);
    logic [7:0] e;
    int         i;
    up = 1'b1;
    cfg.clock_select_field = 3'h0;
    cfg.waveform_mode_field = tmr8_pkg::tmr8_mode_t'(m);
    pulse('{counter_wr: 1'b1, counter_wdata: s, compare_wr: 1'b1, compare_wdata: k, default: '0});
    cyc(2);
    chk8(cnt, s);
    chk8(cmpv, k);
    cfg.async_clock_select = as;
    cfg.clock_select_field = 3'h1;
    e = nxt(m, s, k);
    for (i = 0; i < 100 && cnt === s; i++) cyc(1);
    if (i == 100) begin
      error_cnt++;
      complete_run();
    end
    repeat (n + 1) begin
      chk8(cnt, e);
      e = nxt(m, e, k);
      cyc(1);
    end
    cfg.clock_select_field = 3'h0;
    cfg.async_clock_select = 1'b0;
    cyc(2);
  endtask
  initial begin
    logic [7:0]          k;
    logic                o;
    int                  j;
    tmr8_pkg::tmr8_cpu_t p;
    void'($urandom(32'h4B1D5701));
    cyc(6);
    rst_n_in = 1'b1;
    cyc(1);
    chk8(cnt, 8'h00);
    k = 8'($urandom_range(3, 200));
    run(0, 8'hFC, k, 6, 1'b0);
    chk8(oflag, 1'b1);
    cfg.overflow_irq_enable = 1'b1;
    cyc(2);
    chk8(oirq, 1'b1);
    pulse('{overflow_flag_clr: 1'b1, default: '0});
    chk8(oflag, 1'b0);
    for (j = 0; j < 2; j++) begin
      cfg.compare_irq_enable = !j[0];
      // short first pass stops right after the match tick
      run(0, k - 8'h02, k, 4 * j, 1'b0);
      chk8(cflag, 1'b1);
      chk8(cirq, !j[0]);
      p = '0;
      p.compare_irq_ack = !j[0];
      p.compare_flag_clr = j[0];
      pulse(p);
      chk8(cflag, 1'b0);
      chk8(cirq, 1'b0);
    end
    run(0, k, k, 3, 1'b0);
    chk8(cflag, 1'b0);
    cfg.compare_output_action = 2'h1;
    o = oc;
    pulse('{force_compare_strobe: 1'b1, default: '0});
    chk8(oc, !o);
    chk8(cflag, 1'b0);
    cfg.waveform_mode_field = tmr8_pkg::TMR8_FAST;
    pulse('{force_compare_strobe: 1'b1, default: '0});
    chk8(oc, !o);
    cfg.compare_output_action = 2'h0;
    k = 8'($urandom_range(3, 9));
    run(2, 8'h00, k, 2 * k + 4, 1'b0);
    run(3, 8'hFD, k, 5, 1'b0);
    run(1, 8'hFD, k, 6, 1'b0);
    run(0, 8'h20, k, 0, 1'b1);
    chk8(xpo, !xtal);
    complete_run();
  end
endmodule
`default_nettype wire
